// *** src/ipc_pkg.sv ***
// Constants, register map and types of the interrupt pending set/clear block.
// Assumes a 12-bit APB byte address window and 32-bit data.
package ipc_pkg;

    localparam int unsigned IPC_NUM_SRC   = 39;
    localparam int unsigned IPC_HIGH_SRC  = 7;
    localparam int unsigned IPC_ADDR_W    = 12;
    localparam int unsigned IPC_DATA_W    = 32;
    localparam int unsigned IPC_EVT_W     = 4;

    // Register byte offsets
    localparam logic [11:0] IPC_OFS_FORCE_LOW   = 12'h200;
    localparam logic [11:0] IPC_OFS_FORCE_HIGH  = 12'h204;
    localparam logic [11:0] IPC_OFS_REMOVE_LOW  = 12'h280;
    localparam logic [11:0] IPC_OFS_REMOVE_HIGH = 12'h284;
    localparam logic [11:0] IPC_OFS_EVT_STATUS  = 12'h2a0;
    localparam logic [11:0] IPC_OFS_EVT_MASK    = 12'h2a4;

    // Implemented source positions: 2-3, 12, 14, 16-31 and 32-38
    localparam logic [31:0] IPC_LOW_IMPL  = 32'hffff_500c;
    localparam logic [31:0] IPC_HIGH_IMPL = 32'h0000_007f;
    localparam logic [38:0] IPC_SRC_IMPL  = {IPC_HIGH_IMPL[6:0], IPC_LOW_IMPL};

    // Event bit positions
    localparam int unsigned IPC_EVT_SW_SET  = 0;
    localparam int unsigned IPC_EVT_SW_CLR  = 1;
    localparam int unsigned IPC_EVT_OVERRUN = 2;
    localparam int unsigned IPC_EVT_RSVD_WR = 3;

    // Values after reset
    localparam logic [38:0] IPC_PEND_RST  = 39'h00_0000_0000;
    localparam logic [3:0]  IPC_EVT_RST   = 4'h0;
    localparam logic [3:0]  IPC_MASK_RST  = 4'h0;
    localparam logic [31:0] IPC_RDATA_RST = 32'h0000_0000;

    typedef enum logic {
        IPC_ST_IDLE,
        IPC_ST_ANSWER
    } ipc_apb_state_t;

    typedef enum logic [2:0] {
        IPC_REG_NONE,
        IPC_REG_FORCE_LOW,
        IPC_REG_FORCE_HIGH,
        IPC_REG_REMOVE_LOW,
        IPC_REG_REMOVE_HIGH,
        IPC_REG_EVT_STATUS,
        IPC_REG_EVT_MASK
    } ipc_reg_t;

endpackage

// *** src/ipc_apb_port.sv ***
// APB slave handshake and address decode for the pending set/clear block.
// Assumes an APB master that holds its request until pready is seen high.
`timescale 1ns/1ns
`default_nettype none
module ipc_apb_port (
    input  wire logic                mclk_in,
    input  wire logic                srst_in,
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [11:0]         paddr_in,
    output logic                     pready_out,
    output logic                     pslverr_out,
    output logic                     wr_stb_out,
    output logic                     rd_capture_out,
    output ipc_pkg::ipc_reg_t        reg_sel_out
);

    ipc_pkg::ipc_apb_state_t state_q;
    ipc_pkg::ipc_apb_state_t state_d;

    function automatic ipc_pkg::ipc_reg_t decode(input logic [11:0] addr);
        case (addr)
            ipc_pkg::IPC_OFS_FORCE_LOW:   decode = ipc_pkg::IPC_REG_FORCE_LOW;
            ipc_pkg::IPC_OFS_FORCE_HIGH:  decode = ipc_pkg::IPC_REG_FORCE_HIGH;
            ipc_pkg::IPC_OFS_REMOVE_LOW:  decode = ipc_pkg::IPC_REG_REMOVE_LOW;
            ipc_pkg::IPC_OFS_REMOVE_HIGH: decode = ipc_pkg::IPC_REG_REMOVE_HIGH;
            ipc_pkg::IPC_OFS_EVT_STATUS:  decode = ipc_pkg::IPC_REG_EVT_STATUS;
            ipc_pkg::IPC_OFS_EVT_MASK:    decode = ipc_pkg::IPC_REG_EVT_MASK;
            default:                      decode = ipc_pkg::IPC_REG_NONE;
        endcase
    endfunction

    always_comb begin
        state_d = state_q;
        case (state_q)
            ipc_pkg::IPC_ST_IDLE: begin
                if (psel_in && penable_in) begin
                    state_d = ipc_pkg::IPC_ST_ANSWER;
                end
            end
            ipc_pkg::IPC_ST_ANSWER: begin
                state_d = ipc_pkg::IPC_ST_IDLE;
            end
            default: begin
                state_d = ipc_pkg::IPC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_q <= ipc_pkg::IPC_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // One wait cycle gives time to register read data
    assign reg_sel_out    = decode(paddr_in);
    assign pready_out     = (state_q == ipc_pkg::IPC_ST_ANSWER) && psel_in && penable_in;
    assign pslverr_out    = pready_out && (reg_sel_out == ipc_pkg::IPC_REG_NONE);
    assign wr_stb_out     = pready_out && pwrite_in && (reg_sel_out != ipc_pkg::IPC_REG_NONE);
    assign rd_capture_out = (state_q == ipc_pkg::IPC_ST_IDLE) && psel_in && penable_in && !pwrite_in;

endmodule // ipc_apb_port
`default_nettype wire

// *** src/ipc_event_flags.sv ***
// Sticky event status with write-one-to-clear, mask and one level interrupt.
// Assumes event pulses and write strobes are synchronous to mclk_in.
`timescale 1ns/1ns
`default_nettype none
module ipc_event_flags (
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic [3:0]  evt_in,
    input  wire logic        clr_we_in,
    input  wire logic [3:0]  clr_data_in,
    input  wire logic        mask_we_in,
    input  wire logic [3:0]  mask_data_in,
    output logic      [3:0]  status_out,
    output logic      [3:0]  mask_out,
    output logic             irq_out
);

    logic [3:0] status_q;
    logic [3:0] status_d;
    logic [3:0] mask_q;
    logic [3:0] mask_d;
    logic       irq_q;
    logic       irq_d;

    always_comb begin
        status_d = status_q;
        mask_d   = mask_q;
        if (clr_we_in) begin
            status_d = status_d & ~clr_data_in;
        end
        // A new event wins over a clear in the same cycle
        status_d = status_d | evt_in;
        if (mask_we_in) begin
            mask_d = mask_data_in;
        end
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            status_q <= ipc_pkg::IPC_EVT_RST;
            mask_q   <= ipc_pkg::IPC_MASK_RST;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            irq_q    <= irq_d;
        end
    end

    assign status_out = status_q;
    assign mask_out   = mask_q;
    assign irq_out    = irq_q;

endmodule // ipc_event_flags
`default_nettype wire

// *** src/ipc_pending_top.sv ***
// Pending set/clear control of the fast interrupt controller, on APB.
// Assumes sources and arbitration run on mclk_in; reset is synchronous.
//
// Operation
// - Force-low one in 31:16 sets source pending
// - Force-low bit 14 one sets source 14
// - Force-low bit 12 one sets source 12
// - Force-low bits 3:2 set sources 3, 2
// - Force-high bits 6:0 set sources 32-38
// - Remove-low one in 31:16 clears that source
// - Remove-low bit 14 one clears source 14
// - Remove-low bit 12 one clears source 12
// - Remove-low bits 3:2 clear sources 3, 2
// - Remove-high bits 6:0 clear sources 32-38
//
// The APB register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module ipc_pending_top (
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [38:0] src_req_in,
    input  wire logic [38:0] src_taken_in,
    output logic      [38:0] pending_out,
    output logic             pending_any_out,
    output logic             irq_out
);

    logic                wr_stb;
    logic                rd_capture;
    ipc_pkg::ipc_reg_t   reg_sel;

    logic [38:0]         pend_q;
    logic [38:0]         pend_d;
    logic                pend_any_q;
    logic                pend_any_d;
    logic [31:0]         rdata_q;
    logic [31:0]         rdata_d;

    logic [31:0]         wdata_lanes;
    logic [38:0]         force_bits;
    logic [38:0]         remove_bits;
    logic [38:0]         hw_set_bits;
    logic [38:0]         hw_take_bits;
    logic [3:0]          evt;
    logic                rsvd_hit;
    logic                evt_clr_we;
    logic                evt_mask_we;
    logic [3:0]          evt_status;
    logic [3:0]          evt_mask;

    // Maps one written word onto the source vector, keeping implemented bits only
    function automatic logic [38:0] lane_bits(input logic is_high, input logic [31:0] data);
        logic [38:0] bits;
        bits = 39'h00_0000_0000;
        if (is_high) begin
            bits[38:32] = data[6:0] & ipc_pkg::IPC_HIGH_IMPL[6:0];
        end else begin
            bits[31:0] = data & ipc_pkg::IPC_LOW_IMPL;
        end
        return bits;
    endfunction

    // Returns the word of the pending vector seen at a low or high register
    function automatic logic [31:0] pend_word(input logic is_high, input logic [38:0] pend);
        logic [31:0] word;
        word = 32'h0000_0000;
        if (is_high) begin
            word[6:0] = pend[38:32] & ipc_pkg::IPC_HIGH_IMPL[6:0];
        end else begin
            word = pend[31:0] & ipc_pkg::IPC_LOW_IMPL;
        end
        return word;
    endfunction

    ipc_apb_port u_apb_port (
        .mclk_in        (mclk_in),
        .srst_in        (srst_in),
        .psel_in        (psel_in),
        .penable_in     (penable_in),
        .pwrite_in      (pwrite_in),
        .paddr_in       (paddr_in),
        .pready_out     (pready_out),
        .pslverr_out    (pslverr_out),
        .wr_stb_out     (wr_stb),
        .rd_capture_out (rd_capture),
        .reg_sel_out    (reg_sel)
    );

    // Byte lanes not strobed are treated as written zero, which has no effect except at the event mask, which loads the zero
    always_comb begin
        wdata_lanes = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            if (pstrb_in[i]) begin
                wdata_lanes[i*8 +: 8] = pwdata_in[i*8 +: 8];
            end
        end
    end

    // Write decode into per-source set and clear requests
    always_comb begin
        force_bits  = 39'h00_0000_0000;
        remove_bits = 39'h00_0000_0000;
        rsvd_hit    = 1'b0;
        evt_clr_we  = 1'b0;
        evt_mask_we = 1'b0;
        if (wr_stb) begin
            case (reg_sel)
                ipc_pkg::IPC_REG_FORCE_LOW: begin
                    force_bits = lane_bits(1'b0, wdata_lanes);
                    rsvd_hit   = |(wdata_lanes & ~ipc_pkg::IPC_LOW_IMPL);
                end
                ipc_pkg::IPC_REG_FORCE_HIGH: begin
                    force_bits = lane_bits(1'b1, wdata_lanes);
                    rsvd_hit   = |(wdata_lanes & ~ipc_pkg::IPC_HIGH_IMPL);
                end
                ipc_pkg::IPC_REG_REMOVE_LOW: begin
                    remove_bits = lane_bits(1'b0, wdata_lanes);
                    rsvd_hit    = |(wdata_lanes & ~ipc_pkg::IPC_LOW_IMPL);
                end
                ipc_pkg::IPC_REG_REMOVE_HIGH: begin
                    remove_bits = lane_bits(1'b1, wdata_lanes);
                    rsvd_hit    = |(wdata_lanes & ~ipc_pkg::IPC_HIGH_IMPL);
                end
                ipc_pkg::IPC_REG_EVT_STATUS: begin
                    evt_clr_we = 1'b1;
                end
                ipc_pkg::IPC_REG_EVT_MASK: begin
                    evt_mask_we = 1'b1;
                end
                default: begin
                    rsvd_hit = 1'b0;
                end
            endcase
        end
    end

    // Hardware requests and arbitration takes act on implemented sources only
    assign hw_set_bits  = src_req_in & ipc_pkg::IPC_SRC_IMPL;
    assign hw_take_bits = src_taken_in & ipc_pkg::IPC_SRC_IMPL;

    // Pending state: any set beats any clear in the same cycle
    always_comb begin
        pend_d     = pend_q;
        pend_d     = pend_d & ~remove_bits & ~hw_take_bits;
        pend_d     = pend_d | force_bits | hw_set_bits;
        pend_d     = pend_d & ipc_pkg::IPC_SRC_IMPL;
        pend_any_d = |pend_d;
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pend_q     <= ipc_pkg::IPC_PEND_RST;
            pend_any_q <= 1'b0;
        end else begin
            pend_q     <= pend_d;
            pend_any_q <= pend_any_d;
        end
    end

    // Events for the sticky status register
    always_comb begin
        evt = 4'h0;
        evt[ipc_pkg::IPC_EVT_SW_SET]  = |force_bits;
        evt[ipc_pkg::IPC_EVT_SW_CLR]  = |remove_bits;
        evt[ipc_pkg::IPC_EVT_OVERRUN] = |(hw_set_bits & pend_q & ~hw_take_bits);
        evt[ipc_pkg::IPC_EVT_RSVD_WR] = rsvd_hit;
    end

    ipc_event_flags u_event_flags (
        .mclk_in      (mclk_in),
        .srst_in      (srst_in),
        .evt_in       (evt),
        .clr_we_in    (evt_clr_we),
        .clr_data_in  (wdata_lanes[3:0]),
        .mask_we_in   (evt_mask_we),
        .mask_data_in (wdata_lanes[3:0]),
        .status_out   (evt_status),
        .mask_out     (evt_mask),
        .irq_out      (irq_out)
    );

    // Read data is registered in the first access cycle and held until the next read
    always_comb begin
        rdata_d = rdata_q;
        if (rd_capture) begin
            case (reg_sel)
                ipc_pkg::IPC_REG_FORCE_LOW: begin
                    rdata_d = pend_word(1'b0, pend_q);
                end
                ipc_pkg::IPC_REG_FORCE_HIGH: begin
                    rdata_d = pend_word(1'b1, pend_q);
                end
                ipc_pkg::IPC_REG_REMOVE_LOW: begin
                    rdata_d = pend_word(1'b0, pend_q);
                end
                ipc_pkg::IPC_REG_REMOVE_HIGH: begin
                    rdata_d = pend_word(1'b1, pend_q);
                end
                ipc_pkg::IPC_REG_EVT_STATUS: begin
                    rdata_d = {28'h000_0000, evt_status};
                end
                ipc_pkg::IPC_REG_EVT_MASK: begin
                    rdata_d = {28'h000_0000, evt_mask};
                end
                default: begin
                    rdata_d = ipc_pkg::IPC_RDATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rdata_q <= ipc_pkg::IPC_RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata_out      = rdata_q;
    assign pending_out     = pend_q;
    assign pending_any_out = pend_any_q;

endmodule // ipc_pending_top
`default_nettype wire

// *** verification/ipc_pending_props.sv ***
// Assertions on the ports of the pending set/clear block.
// Assumes it is bound to ipc_pending_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module ipc_pending_props (
    input wire logic        mclk_in,
    input wire logic        srst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0]  pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [38:0] src_req_in,
    input wire logic [38:0] src_taken_in,
    input wire logic [38:0] pending_out
);
    logic [31:0] wd;
    logic [31:0] req_lo;
    logic [6:0]  req_hi;
    logic        wdone;
    logic        rdone;
    // Unstrobed lanes count as zero
    assign wd = pwdata_in & {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    assign req_lo = src_req_in[31:0];
    assign req_hi = src_req_in[38:32];
    assign wdone = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;
    assign rdone = psel_in & penable_in & pready_out & ~pwrite_in;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    force_low_a:
    assert property (wdone && paddr_in == ipc_pkg::IPC_OFS_FORCE_LOW |=>
        (pending_out[31:0] & $past(wd) & ipc_pkg::IPC_LOW_IMPL) == ($past(wd) & ipc_pkg::IPC_LOW_IMPL))
        else $error("force low write did not set sources");
    force_high_a:
    assert property (wdone && paddr_in == ipc_pkg::IPC_OFS_FORCE_HIGH |=>
        (pending_out[38:32] & $past(wd[6:0])) == $past(wd[6:0]))
        else $error("force high write did not set sources");
    remove_low_a:
    assert property (wdone && paddr_in == ipc_pkg::IPC_OFS_REMOVE_LOW |=>
        (pending_out[31:0] & $past(wd) & ~$past(req_lo)) == 32'h0000_0000)
        else $error("remove low write left sources pending");
    remove_high_a:
    assert property (wdone && paddr_in == ipc_pkg::IPC_OFS_REMOVE_HIGH |=>
        (pending_out[38:32] & $past(wd[6:0]) & ~$past(req_hi)) == 7'h00)
        else $error("remove high write left sources pending");
    zero_noop_a:
    assert property (wdone && paddr_in == ipc_pkg::IPC_OFS_FORCE_LOW && src_taken_in == '0 |=>
        (pending_out & $past(pending_out)) == $past(pending_out))
        else $error("force write cleared a source");
    req_wins_a:
    assert property (|src_req_in |=> (pending_out & $past(src_req_in) & ipc_pkg::IPC_SRC_IMPL)
        == ($past(src_req_in) & ipc_pkg::IPC_SRC_IMPL))
        else $error("request lost against a clear");
    unimpl_zero_a:
    assert property ((pending_out & ~ipc_pkg::IPC_SRC_IMPL) == '0)
        else $error("unimplemented source pending");
    rsvd_read_a:
    assert property (rdone && paddr_in == ipc_pkg::IPC_OFS_FORCE_LOW |->
        (prdata_out & ~ipc_pkg::IPC_LOW_IMPL) == 32'h0000_0000)
        else $error("reserved bits read nonzero");
    cover property (wdone && paddr_in == ipc_pkg::IPC_OFS_REMOVE_LOW && |src_req_in);
    cover property (pslverr_out);
    cover property (rdone && paddr_in == ipc_pkg::IPC_OFS_FORCE_HIGH);
endmodule // ipc_pending_props
bind ipc_pending_top ipc_pending_props u_props (.mclk_in, .srst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .src_req_in,
    .src_taken_in, .pending_out);
`default_nettype wire

// *** verification/test_interrupt_pending_set_clear.sv ***
// Self-checking bench of the pending set/clear block over APB.
// Assumes ipc_pkg, the design and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_pending_set_clear;
    localparam logic [11:0] a_fl = ipc_pkg::IPC_OFS_FORCE_LOW;
    localparam logic [11:0] a_fh = ipc_pkg::IPC_OFS_FORCE_HIGH;
    localparam logic [11:0] a_rl = ipc_pkg::IPC_OFS_REMOVE_LOW;
    localparam logic [11:0] a_rh = ipc_pkg::IPC_OFS_REMOVE_HIGH;
    localparam logic [11:0] a_st = ipc_pkg::IPC_OFS_EVT_STATUS;
    localparam logic [11:0] a_mk = ipc_pkg::IPC_OFS_EVT_MASK;
    logic        mclk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic [3:0]  pstrb_in = 4'h0;
    logic [38:0] src_req_in = '0;
    logic [38:0] src_taken_in = '0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        pending_any_out;
    logic        irq_out;
    logic [38:0] pending_out;
    logic [38:0] pend = '0;
    logic [65:0] q[$];
    int          fails = 0;
    int          total_checks = 0;
    int          seed = 90293;
    logic [11:0] adrs[4] = '{a_fl, a_fh, a_rl, a_rh};

    ipc_pending_top u_dut (.mclk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .src_req_in, .src_taken_in, .pending_out,
        .pending_any_out, .irq_out);

    initial forever #25 mclk_in = ~mclk_in;

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Setup, access, then release at the edge where pready is high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= s;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(negedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            conclude();
        end
        @(posedge mclk_in);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    function automatic logic [32:0] view(input logic [11:0] a);
        if (a == a_fl || a == a_rl) return {1'b0, pend[31:0]};
        if (a == a_fh || a == a_rh) return {26'h0, pend[38:32]};
        return {1'b1, 32'h0000_0000};
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] e;
        e = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        xfer(1'b1, a, d, s);
        if (a == a_fl) pend[31:0] = pend[31:0] | e;
        if (a == a_fh) pend[38:32] = pend[38:32] | e[6:0];
        if (a == a_rl) pend[31:0] = pend[31:0] & ~e;
        if (a == a_rh) pend[38:32] = pend[38:32] & ~e[6:0];
        pend = pend & ipc_pkg::IPC_SRC_IMPL;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] exp, input logic [32:0] m);
        q.push_back({m, exp & m});
        xfer(1'b0, a, 32'h0000_0000, 4'h0);
    endtask

    task automatic chk_irq(input logic exp);
        @(negedge mclk_in);
        check({32'h0, irq_out}, {32'h0, exp});
    endtask

    // Pending vector and its summary against the model, once settled
    task automatic chk_pend;
        @(negedge mclk_in);
        check({1'b0, pending_out[31:0]}, {1'b0, pend[31:0]});
        check({26'h0, pending_out[38:32]}, {26'h0, pend[38:32]});
        check({32'h0, pending_any_out}, {32'h0, |pend});
    endtask

    // Read results are compared against the oldest queued note
    always @(negedge mclk_in) begin
        logic [65:0] e;
        if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in) begin
            if (q.size() == 0) begin
                fails++;
                $display("mismatch at %0t: unexpected read", $time);
            end else begin
                e = q.pop_front();
                check({pslverr_out, prdata_out} & e[65:33], e[32:0]);
            end
        end
    end

    initial begin
        logic [31:0] d;
        logic [3:0]  s;
        repeat (4) @(posedge mclk_in);
        srst_in <= 1'b0;
        foreach (adrs[k]) rd(adrs[k], view(adrs[k]), '1);
        rd(a_st, 33'h0, '1);
        rd(a_mk, 33'h0, '1);
        rd(12'h208, view(12'h208), '1);
        wr(a_fl, 32'hffff_ffff, 4'hf);
        wr(a_fh, 32'hffff_ffff, 4'hf);
        wr(12'h208, 32'h0000_0000, 4'hf);
        wr(a_rl, 32'h0000_0000, 4'hf);
        foreach (adrs[k]) rd(adrs[k], view(adrs[k]), '1);
        wr(a_rl, 32'h0000_500c, 4'hf);
        wr(a_rh, 32'h0000_0055, 4'h1);
        foreach (adrs[k]) rd(adrs[k], view(adrs[k]), '1);
        for (int i = 0; i < 24; i++) begin
            d = $random(seed);
            s = 4'($random(seed));
            wr(adrs[i % 4], d, s);
            chk_pend();
            rd(adrs[(i + 1) % 4], view(adrs[(i + 1) % 4]), '1);
        end
        // A clear meeting a live request loses
        wr(a_fl, 32'h0010_0000, 4'hf);
        src_req_in <= 39'h00_0010_0000;
        wr(a_rl, 32'h0010_0000, 4'hf);
        pend[20] = 1'b1;
        src_req_in <= '0;
        rd(a_rl, view(a_rl), '1);
        wr(a_fl, 32'h0001_0000, 4'h4);
        src_taken_in <= 39'h00_0001_0000;
        @(posedge mclk_in);
        src_taken_in <= '0;
        pend[16] = 1'b0;
        rd(a_fl, view(a_fl), '1);
        // Reserved-bit write event raises, masks and clears the interrupt
        wr(a_st, 32'h0000_000f, 4'hf);
        wr(a_mk, 32'h0000_0008, 4'hf);
        chk_irq(1'b0);
        wr(a_fl, 32'h0000_0001, 4'h1);
        chk_irq(1'b1);
        rd(a_st, 33'h0_0000_0008, 33'h1_0000_0008);
        rd(a_mk, 33'h0_0000_0008, '1);
        wr(a_mk, 32'h0000_0000, 4'hf);
        chk_irq(1'b0);
        wr(a_mk, 32'h0000_0008, 4'hf);
        chk_irq(1'b1);
        wr(a_st, 32'h0000_0008, 4'hf);
        chk_irq(1'b0);
        // Software set, software clear and a request on a pending source each log an event
        wr(a_fl, 32'h0000_0004, 4'h1);
        wr(a_rl, 32'h0000_0004, 4'h1);
        src_req_in <= 39'h00_0000_0004;
        repeat (2) @(posedge mclk_in);
        src_req_in <= '0;
        pend[2] = 1'b1;
        chk_pend();
        rd(a_st, 33'h0_0000_0007, '1);
        chk_irq(1'b0);
        conclude();
    end
endmodule // test_interrupt_pending_set_clear
`default_nettype wire
